/* File: rtl/ext_irq_detect.sv */
// One external interrupt input: pin select, synchroniser and mode detection.
`timescale 1ns/1ps
module ext_irq_detect #(
  parameter int PINS = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Port pins and configuration
  input wire logic [PINS-1:0] port_pins,
  input wire logic [irq_pkg::PIN_SEL_W-1:0] pin_select,
  input wire logic polarity,
  input wire logic edge_select,
  // Detection results
  output logic active_level,
  output logic edge_event
);
  import irq_pkg::*;

  initial begin
    if (PINS < 1 || PINS > (1 << PIN_SEL_W)) begin
      $error("PINS out of range");
    end
  end

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic pin_raw;
  logic act_now;

  // The selected pin is only observed, so routing of the pin elsewhere is untouched.
  assign pin_raw = port_pins[pin_select];

  // ****************************************************************
  // Two flip-flop synchroniser
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    // Resetting to the idle level keeps a false edge or level out of the first cycles.
    if (rst) begin
      sync1_q <= !polarity;
      sync2_q <= !polarity;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  assign act_now = (sync2_q == polarity);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= act_now;
    end
  end

  assign active_level = act_now;
  assign edge_event = edge_select && act_now && !prev_q;
endmodule

/* File: rtl/irq_pkg.sv */
// Shared constants for the two-level vectored interrupt handler.
package irq_pkg;

  // ****************************************************************
  // Source count and ranks
  // ****************************************************************
  localparam int NUM_SRC = 12;
  localparam int SRC_W = 4;
  localparam logic [SRC_W-1:0] RANK_EXT0 = 4'h0;
  localparam logic [SRC_W-1:0] RANK_TMR0 = 4'h1;
  localparam logic [SRC_W-1:0] RANK_EXT1 = 4'h2;
  localparam logic [SRC_W-1:0] RANK_TMR1 = 4'h3;

  // ****************************************************************
  // Vector table
  // ****************************************************************
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;

  // ****************************************************************
  // Register field positions and reset values
  // ****************************************************************
  localparam int GLOBAL_EN_BIT = 7;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [NUM_SRC-1:0] PRIO_RESET = 12'h000;
  localparam logic [NUM_SRC-1:0] PEND_RESET = 12'h000;
  localparam int PIN_SEL_W = 3;

  // ****************************************************************
  // Timing in system clocks
  // ****************************************************************
  localparam int DETECT_CLKS = 1;
  localparam int CALL_CLKS = 4;
  localparam int RETURN_CLKS = 5;
  localparam int DIV_CLKS = 8;
  localparam int MIN_RESPONSE_CLKS = DETECT_CLKS + CALL_CLKS;
  localparam int MAX_RESPONSE_CLKS = DETECT_CLKS + RETURN_CLKS + DIV_CLKS + CALL_CLKS;

  typedef enum logic [1:0] {
    SVC_NONE,
    SVC_LOW,
    SVC_HIGH
  } svc_level_t;

endpackage

/* File: rtl/vectored_irq_handler.sv */
// Two-level vectored interrupt handler with twelve sources.
// Summary of operation
// - Twelve sources, each assigned one of two priority levels.
// - Pending flag sets on source event regardless of any enable.
// - Enabled pending source requests a long call to its vector after instruction.
// - Return from interrupt resumes the interrupted instruction stream.
// - Disabled source with pending flag raises no request.
// - Global enable bit 7 gates all individual enables.
// - Clearing global enable may still admit one request before single-cycle instruction.
// - Flag still set after return re-requests after exactly one instruction.
// - Software writing one to a pending flag acts like a hardware event.
// - External inputs have edge/level type and high/low polarity bits.
// - External inputs watch a selected port pin without disturbing it.
// - Edge-mode external flag clears when the call to its vector happens.
// - Level-mode external flag follows the active state of the input.
// - High priority preempts low service; high service is never preempted.
// - Higher level wins; within level lowest rank wins.
// - Requests sampled each clock; fastest response five clocks.
// - Request during return waits one instruction; worst case eighteen clocks.
// - Equal or lower request waits for return plus next instruction.
// - Vectors start at 0x0003 and step by eight per rank.
// - Only edge external and timer overflow flags clear on vectoring.
`timescale 1ns/1ps
module vectored_irq_handler #(
  parameter int PINS = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Enable and priority registers
  input wire logic [7:0] irq_enable_reg,
  input wire logic [7:0] ext_irq_enable_reg,
  input wire logic [7:0] irq_priority_reg,
  input wire logic [7:0] ext_irq_priority_reg,
  // External input configuration
  input wire logic [PINS-1:0] port_pins,
  input wire logic [irq_pkg::PIN_SEL_W-1:0] ext_in0_pin_sel,
  input wire logic [irq_pkg::PIN_SEL_W-1:0] ext_in1_pin_sel,
  input wire logic ext_in0_polarity,
  input wire logic ext_in1_polarity,
  input wire logic ext_in0_edge_select,
  input wire logic ext_in1_edge_select,
  // Peripheral events and software access to pending flags
  input wire logic [irq_pkg::NUM_SRC-1:0] periph_event,
  input wire logic [irq_pkg::NUM_SRC-1:0] sw_set_pending,
  input wire logic [irq_pkg::NUM_SRC-1:0] sw_clr_pending,
  // CPU sequencer
  input wire logic instr_boundary,
  input wire logic next_multi_cycle,
  input wire logic call_taken,
  input wire logic return_done,
  // Outputs
  output logic [irq_pkg::NUM_SRC-1:0] pending_flags,
  output logic irq_request,
  output logic [15:0] irq_vector,
  output logic [irq_pkg::SRC_W-1:0] irq_rank,
  output logic in_service_low,
  output logic in_service_high
);
  import irq_pkg::*;

  initial begin
    if (PINS < 2) begin
      $error("PINS must be at least 2");
    end
  end

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [15:0] vector_of(input logic [SRC_W-1:0] rank);
    vector_of = VEC_BASE + VEC_STEP * {12'h000, rank};
  endfunction

  function automatic logic [SRC_W:0] first_set(input logic [NUM_SRC-1:0] v);
    first_set = {1'b0, 4'hf};
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = {1'b1, SRC_W'(i)};
      end
    end
  endfunction

  function automatic logic hw_clears(input logic [SRC_W-1:0] rank, input logic e0,
                                     input logic e1);
    hw_clears = (rank == RANK_TMR0) || (rank == RANK_TMR1) ||
                (rank == RANK_EXT0 && e0) || (rank == RANK_EXT1 && e1);
  endfunction

  // ****************************************************************
  // External inputs
  // ****************************************************************
  logic ext0_level;
  logic ext0_edge;
  logic ext1_level;
  logic ext1_edge;

  ext_irq_detect #(
    .PINS(PINS)
  ) u_ext0 (
    .ref_clk(ref_clk),
    .rst(rst),
    .port_pins(port_pins),
    .pin_select(ext_in0_pin_sel),
    .polarity(ext_in0_polarity),
    .edge_select(ext_in0_edge_select),
    .active_level(ext0_level),
    .edge_event(ext0_edge)
  );

  ext_irq_detect #(
    .PINS(PINS)
  ) u_ext1 (
    .ref_clk(ref_clk),
    .rst(rst),
    .port_pins(port_pins),
    .pin_select(ext_in1_pin_sel),
    .polarity(ext_in1_polarity),
    .edge_select(ext_in1_edge_select),
    .active_level(ext1_level),
    .edge_event(ext1_edge)
  );

  // ****************************************************************
  // Pending flags
  // ****************************************************************
  logic [NUM_SRC-1:0] pend_q;
  logic [NUM_SRC-1:0] enable_vec;
  logic [NUM_SRC-1:0] prio_vec;
  logic [NUM_SRC-1:0] hw_event;
  logic [NUM_SRC-1:0] vec_clear;
  logic [SRC_W-1:0] win_rank;
  logic req_q;
  logic req_high_q;
  logic [SRC_W-1:0] rank_q;
  logic global_en;

  assign enable_vec = {ext_irq_enable_reg[5:0], irq_enable_reg[5:0]};
  assign prio_vec = {ext_irq_priority_reg[5:0], irq_priority_reg[5:0]};
  assign global_en = irq_enable_reg[GLOBAL_EN_BIT];

  always_comb begin
    hw_event = periph_event;
    hw_event[RANK_EXT0] = ext0_edge;
    hw_event[RANK_EXT1] = ext1_edge;
  end

  always_comb begin
    vec_clear = '0;
    // The source cleared is the one whose vector is being called, not the live winner.
    if (call_taken && req_q &&
        hw_clears(rank_q, ext_in0_edge_select, ext_in1_edge_select)) begin
      vec_clear[rank_q] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_pend
      if (gi == RANK_EXT0 || gi == RANK_EXT1) begin : g_ext
        logic lvl_mode;
        logic lvl_in;
        assign lvl_mode = (gi == RANK_EXT0) ? !ext_in0_edge_select : !ext_in1_edge_select;
        assign lvl_in = (gi == RANK_EXT0) ? ext0_level : ext1_level;
        always_ff @(posedge ref_clk) begin
          if (rst) begin
            pend_q[gi] <= PEND_RESET[gi];
          end else if (lvl_mode) begin
            pend_q[gi] <= lvl_in;
          end else if (hw_event[gi] || sw_set_pending[gi]) begin
            pend_q[gi] <= 1'b1;
          end else if (vec_clear[gi] || sw_clr_pending[gi]) begin
            pend_q[gi] <= 1'b0;
          end
        end
      end else begin : g_int
        always_ff @(posedge ref_clk) begin
          if (rst) begin
            pend_q[gi] <= PEND_RESET[gi];
          end else if (hw_event[gi] || sw_set_pending[gi]) begin
            pend_q[gi] <= 1'b1;
          end else if (vec_clear[gi] || sw_clr_pending[gi]) begin
            pend_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign pending_flags = pend_q;

  // ****************************************************************
  // Global enable shadow
  // ****************************************************************
  // The enable seen by arbitration lags one instruction boundary when a clear
  // is followed by a single-cycle instruction, so one request may slip past.
  logic global_en_q;
  logic eff_global;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      global_en_q <= 1'b0;
    end else if (instr_boundary) begin
      global_en_q <= global_en;
    end
  end

  assign eff_global = global_en || (global_en_q && !next_multi_cycle);

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  logic [NUM_SRC-1:0] active_req;
  logic [NUM_SRC-1:0] high_req;
  logic [SRC_W:0] hi_pick;
  logic [SRC_W:0] lo_pick;
  logic win_high;
  logic win_valid;
  logic svc_hi_q;
  logic svc_lo_q;
  logic hold_q;
  logic allowed;

  assign active_req = pend_q & enable_vec & {NUM_SRC{eff_global}};
  assign high_req = active_req & prio_vec;
  assign hi_pick = first_set(high_req);
  assign lo_pick = first_set(active_req & ~prio_vec);
  assign win_high = hi_pick[SRC_W];
  assign win_valid = hi_pick[SRC_W] || lo_pick[SRC_W];
  assign win_rank = win_high ? hi_pick[SRC_W-1:0] : lo_pick[SRC_W-1:0];

  // Preemption only for high over low; nothing preempts high service.
  assign allowed = win_high ? !svc_hi_q : (!svc_hi_q && !svc_lo_q);

  // ****************************************************************
  // Post-return hold: one instruction must execute after a return
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold_q <= 1'b0;
    end else if (return_done) begin
      hold_q <= 1'b1;
    end else if (instr_boundary) begin
      hold_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Request and vector outputs
  // ****************************************************************
  logic [15:0] vec_q;

  // Sampled every clock; the sequencer calls at its next instruction boundary.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_q <= 1'b0;
      req_high_q <= 1'b0;
      vec_q <= VEC_RESET;
      rank_q <= '0;
    end else begin
      req_high_q <= win_high;
      req_q <= win_valid && allowed && !hold_q && !return_done && !call_taken;
      vec_q <= vector_of(win_rank);
      rank_q <= win_rank;
    end
  end

  assign irq_request = req_q;
  assign irq_vector = vec_q;
  assign irq_rank = rank_q;

  // ****************************************************************
  // Service levels
  // ****************************************************************
  // Return ends the innermost level, which is high whenever it is active.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      svc_hi_q <= 1'b0;
      svc_lo_q <= 1'b0;
    end else if (call_taken && req_q) begin
      if (req_high_q) begin
        svc_hi_q <= 1'b1;
      end else begin
        svc_lo_q <= 1'b1;
      end
    end else if (return_done) begin
      if (svc_hi_q) begin
        svc_hi_q <= 1'b0;
      end else begin
        svc_lo_q <= 1'b0;
      end
    end
  end

  assign in_service_low = svc_lo_q;
  assign in_service_high = svc_hi_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_disabled_no_req: assert property (@(posedge ref_clk) disable iff (rst)
    (active_req == '0) |=> !irq_request) else $error("request without enabled source");

  chk_global_mask: assert property (@(posedge ref_clk) disable iff (rst)
    (!global_en && !global_en_q) |=> !irq_request) else $error("request while masked");

  chk_hold_after_ret: assert property (@(posedge ref_clk) disable iff (rst)
    return_done |=> !irq_request) else $error("request right after return");

  chk_vector_map: assert property (@(posedge ref_clk) disable iff (rst)
    irq_request |-> irq_vector == VEC_BASE + VEC_STEP * {12'h000, irq_rank})
    else $error("vector does not match rank");

  chk_high_no_preempt: assert property (@(posedge ref_clk) disable iff (rst)
    $past(svc_hi_q) && svc_hi_q && $past(!return_done) |-> !irq_request)
    else $error("high service preempted");

  chk_return_high: assert property (@(posedge ref_clk) disable iff (rst)
    return_done && in_service_high && !call_taken |=> !in_service_high)
    else $error("return did not end high service");

  chk_pending_sets: assert property (@(posedge ref_clk) disable iff (rst)
    periph_event[5] |=> pending_flags[5]) else $error("flag not set on event");

  chk_sw_set: assert property (@(posedge ref_clk) disable iff (rst)
    sw_set_pending[8] |=> pending_flags[8]) else $error("software set lost");

  chk_edge_clear: assert property (@(posedge ref_clk) disable iff (rst)
    call_taken && irq_request && irq_rank == RANK_TMR0 && !hw_event[1] && !sw_set_pending[1]
    |=> !pending_flags[1]) else $error("timer flag not cleared on call");

  chk_level_track: assert property (@(posedge ref_clk) disable iff (rst)
    !ext_in0_edge_select && $past(!ext_in0_edge_select)
    |-> pending_flags[0] == $past(ext0_level)) else $error("level flag does not track input");

  chk_level_track_one: assert property (@(posedge ref_clk) disable iff (rst)
    !ext_in1_edge_select && $past(!ext_in1_edge_select)
    |-> pending_flags[2] == $past(ext1_level)) else $error("level flag one does not track input");

  chk_fast_resp: assert property (@(posedge ref_clk) disable iff (rst)
    win_valid && allowed && !hold_q && !return_done && !call_taken |=> irq_request)
    else $error("request not raised within one clock");
endmodule

/* File: testbench/cpu_seq_model.sv */
// CPU sequencer model that answers vector requests with a call pulse.
`timescale 1ns/1ps
module cpu_seq_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control from the bench
  input wire logic go,
  input wire logic [3:0] delay,
  input wire logic multi_cycle,
  // Handler side
  input wire logic irq_request,
  output logic call_taken,
  output logic next_multi_cycle
);
  logic [3:0] wait_q;

  // The bench picks the instruction after a global disable; software should pick a long one.
  assign next_multi_cycle = multi_cycle;

  // The call is only started while the request stands, after a chosen wait.
  always_ff @(posedge ref_clk) begin
    if (rst || !go) begin
      wait_q <= 4'h0;
      call_taken <= 1'b0;
    end else if (call_taken) begin
      wait_q <= 4'h0;
      call_taken <= 1'b0;
    end else if (irq_request && wait_q >= delay) begin
      call_taken <= 1'b1;
    end else if (irq_request) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      wait_q <= 4'h0;
    end
  end
endmodule

/* File: testbench/tb_vectored_irq_handler.sv */
// Self-checking bench for the two-level vectored interrupt handler.
`timescale 1ns/1ps
module tb_vectored_irq_handler;
  import irq_pkg::*;
  logic ref_clk, rst, go, multi, pol0, pol1, edge0, edge1;
  logic [7:0] irq_enable_reg, ext_irq_enable_reg, irq_priority_reg, ext_irq_priority_reg;
  logic [7:0] port_pins;
  logic [PIN_SEL_W-1:0] sel0, sel1;
  logic [NUM_SRC-1:0] periph_event, sw_set_pending, sw_clr_pending, pending_flags;
  logic instr_boundary, next_multi_cycle, call_taken, return_done;
  logic irq_request, in_service_low, in_service_high;
  logic [15:0] irq_vector;
  logic [SRC_W-1:0] irq_rank;
  logic [3:0] delay;
  int fail_count, checked;

  vectored_irq_handler #(.PINS(8)) vectored_irq_handler_i (
    .ref_clk(ref_clk), .rst(rst),
    .irq_enable_reg(irq_enable_reg), .ext_irq_enable_reg(ext_irq_enable_reg),
    .irq_priority_reg(irq_priority_reg), .ext_irq_priority_reg(ext_irq_priority_reg),
    .port_pins(port_pins), .ext_in0_pin_sel(sel0), .ext_in1_pin_sel(sel1),
    .ext_in0_polarity(pol0), .ext_in1_polarity(pol1),
    .ext_in0_edge_select(edge0), .ext_in1_edge_select(edge1),
    .periph_event(periph_event), .sw_set_pending(sw_set_pending),
    .sw_clr_pending(sw_clr_pending), .instr_boundary(instr_boundary),
    .next_multi_cycle(next_multi_cycle), .call_taken(call_taken),
    .return_done(return_done), .pending_flags(pending_flags),
    .irq_request(irq_request), .irq_vector(irq_vector), .irq_rank(irq_rank),
    .in_service_low(in_service_low), .in_service_high(in_service_high));

  cpu_seq_model cpu_seq_model_i (
    .ref_clk(ref_clk), .rst(rst), .go(go), .delay(delay), .irq_request(irq_request),
    .multi_cycle(multi),
    .call_taken(call_taken), .next_multi_cycle(next_multi_cycle));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  // Kinds: 0 event, 1 software set, 2 software clear, 3 return, 4 boundary.
  task automatic pulse(input int kind, input logic [NUM_SRC-1:0] m);
    case (kind)
      0: periph_event = m;
      1: sw_set_pending = m;
      2: sw_clr_pending = m;
      3: return_done = 1'b1;
      default: instr_boundary = 1'b1;
    endcase
    tick(1);
    case (kind)
      0: periph_event = 12'h000;
      1: sw_set_pending = 12'h000;
      2: sw_clr_pending = 12'h000;
      3: return_done = 1'b0;
      default: instr_boundary = 1'b0;
    endcase
  endtask

  task automatic wait_req();
    int i;
    i = 0;
    while (irq_request !== 1'b1 && i < 8) begin
      tick(1);
      i++;
    end
    cmp_bit(irq_request, 1'b1);
  endtask

  task automatic wait_flag(input int b, input logic v);
    int i;
    i = 0;
    while (pending_flags[b] !== v && i < 8) begin
      tick(1);
      i++;
    end
  endtask

  task automatic take_call(input logic [3:0] d);
    int i;
    i = 0;
    delay = d;
    go = 1'b1;
    while (call_taken !== 1'b1 && i < 20) begin
      tick(1);
      i++;
    end
    cmp_bit(call_taken, 1'b1);
    tick(1);
    go = 1'b0;
    cmp_bit(irq_request, 1'b0);
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    stop_test();
  end

  initial begin
    fail_count = 0;
    checked = 0;
    rst = 1'b1;
    go = 1'b0;
    delay = 4'h0;
    multi = 1'b1;
    irq_enable_reg = 8'h3f;
    ext_irq_enable_reg = 8'h3f;
    irq_priority_reg = 8'h00;
    ext_irq_priority_reg = 8'h00;
    port_pins = 8'h20;
    sel0 = 3'h3;
    sel1 = 3'h5;
    pol0 = 1'b1;
    pol1 = 1'b0;
    edge0 = 1'b1;
    edge1 = 1'b0;
    periph_event = 12'h000;
    sw_set_pending = 12'h000;
    sw_clr_pending = 12'h000;
    instr_boundary = 1'b0;
    return_done = 1'b0;
    tick(20);
    cmp_val({4'h0, pending_flags}, 16'h0000);
    cmp_val(irq_vector, 16'h0000);
    rst = 1'b0;
    tick(3);
    // Global enable off: flag sets, no request.
    pulse(0, 12'h020);
    cmp_bit(pending_flags[5], 1'b1);
    tick(3);
    cmp_bit(irq_request, 1'b0);
    irq_enable_reg = 8'hbf;
    tick(1);
    cmp_bit(irq_request, 1'b1);
    cmp_val(irq_vector, 16'h002b);
    take_call(4'h0);
    cmp_bit(in_service_low, 1'b1);
    cmp_bit(pending_flags[5], 1'b1);
    pulse(2, 12'h020);
    pulse(3, 12'h000);
    cmp_bit(in_service_low, 1'b0);
    pulse(4, 12'h000);
    // Every peripheral rank through a software set.
    for (int r = 1; r < NUM_SRC; r++) begin
      if (r != 2) begin
        pulse(1, 12'h001 << r);
        tick(1);
        cmp_bit(irq_request, 1'b1);
        cmp_val(irq_vector, 16'h0003 + 16'(r * 8));
        cmp_val({12'h000, irq_rank}, 16'(r));
        take_call(4'(r % 4));
        cmp_bit(pending_flags[r], (r == 1 || r == 3) ? 1'b0 : 1'b1);
        pulse(2, 12'h001 << r);
        pulse(3, 12'h000);
        pulse(4, 12'h000);
      end
    end
    // Global disable followed by a single-cycle instruction still admits a request.
    irq_enable_reg = 8'h3f;
    multi = 1'b0;
    pulse(1, 12'h010);
    tick(1);
    cmp_bit(irq_request, 1'b1);
    multi = 1'b1;
    tick(1);
    cmp_bit(irq_request, 1'b0);
    pulse(2, 12'h010);
    irq_enable_reg = 8'hbf;
    // Two requests together, then a level change.
    pulse(1, 12'h090);
    tick(1);
    cmp_val(irq_vector, 16'h0023);
    ext_irq_priority_reg = 8'h02;
    tick(1);
    cmp_val(irq_vector, 16'h003b);
    take_call(4'h0);
    cmp_bit(in_service_high, 1'b1);
    tick(2);
    cmp_bit(irq_request, 1'b0);
    pulse(2, 12'h080);
    pulse(3, 12'h000);
    cmp_bit(in_service_high, 1'b0);
    tick(2);
    cmp_bit(irq_request, 1'b0);
    pulse(4, 12'h000);
    wait_req();
    cmp_val(irq_vector, 16'h0023);
    take_call(4'h2);
    cmp_bit(in_service_low, 1'b1);
    // High request preempts the low routine.
    ext_irq_priority_reg = 8'h01;
    pulse(1, 12'h040);
    tick(1);
    cmp_val(irq_vector, 16'h0033);
    take_call(4'h0);
    cmp_bit(in_service_high, 1'b1);
    pulse(2, 12'h050);
    pulse(3, 12'h000);
    cmp_bit(in_service_low, 1'b1);
    pulse(4, 12'h000);
    pulse(3, 12'h000);
    cmp_bit(in_service_low, 1'b0);
    pulse(4, 12'h000);
    // External input 0, rising edge on pin 3.
    port_pins = 8'h28;
    wait_flag(0, 1'b1);
    cmp_bit(pending_flags[0], 1'b1);
    wait_req();
    cmp_val(irq_vector, 16'h0003);
    take_call(4'h0);
    cmp_bit(pending_flags[0], 1'b0);
    port_pins = 8'h30;
    tick(6);
    cmp_bit(pending_flags[0], 1'b0);
    pulse(3, 12'h000);
    pulse(4, 12'h000);
    // External input 1, active low level on pin 5.
    port_pins = 8'h00;
    wait_flag(2, 1'b1);
    cmp_bit(pending_flags[2], 1'b1);
    wait_req();
    cmp_val(irq_vector, 16'h0013);
    take_call(4'h1);
    cmp_bit(pending_flags[2], 1'b1);
    port_pins = 8'h20;
    wait_flag(2, 1'b0);
    cmp_bit(pending_flags[2], 1'b0);
    pulse(3, 12'h000);
    pulse(4, 12'h000);
    tick(3);
    cmp_bit(irq_request, 1'b0);
    // Input 0 active low level on pin 6, input 1 active high edge on pin 4.
    irq_enable_reg = 8'hba;
    edge0 = 1'b0;
    pol0 = 1'b0;
    sel0 = 3'h6;
    edge1 = 1'b1;
    pol1 = 1'b1;
    sel1 = 3'h4;
    tick(4);
    pulse(2, 12'h004);
    cmp_bit(pending_flags[0], 1'b1);
    cmp_bit(pending_flags[2], 1'b0);
    irq_enable_reg = 8'hbf;
    wait_req();
    cmp_val(irq_vector, 16'h0003);
    take_call(4'h0);
    cmp_bit(pending_flags[0], 1'b1);
    port_pins = 8'h70;
    wait_flag(0, 1'b0);
    cmp_bit(pending_flags[0], 1'b0);
    wait_flag(2, 1'b1);
    cmp_bit(pending_flags[2], 1'b1);
    cmp_bit(irq_request, 1'b0);
    pulse(3, 12'h000);
    pulse(4, 12'h000);
    wait_req();
    cmp_val(irq_vector, 16'h0013);
    take_call(4'h0);
    cmp_bit(pending_flags[2], 1'b0);
    pulse(3, 12'h000);
    pulse(4, 12'h000);
    stop_test();
  end
endmodule
